// ==== phy_specific_config_bits.sv ====
// lower control bits of the transceiver specific configuration register
// assumes one AHB-Lite master, line status inputs from other clock domains
`timescale 1ns/100ps
module phy_specific_config_bits
  import phy_cfg_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       resetn,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire phy_cfg_pkg::line_status_t  line_status,
  input  wire logic                       line_idle,
  output logic                            speed_indicator_pin,
  output logic                            duplex_collision_pin,
  output logic                            reduced_power_down,
  output logic                            fsm_reset_active,
  output logic                            preamble_skip_en,
  output logic                            sleep_power_down,
  output logic                            remote_loopback_en
);
  import phy_cfg_pkg::*;

  cfg_t                    cfg;
  line_status_t            sync1;
  line_status_t            sync2;
  logic                    idle_s1;
  logic                    idle_s2;
  logic                    wr_pending;
  logic [2:0]              reset_count;
  logic                    sleep_prev;
  logic [15:0]             read_value;
  logic                    addr_hit;

  function automatic logic is_cfg_addr(input logic [31:0] a);
    is_cfg_addr = (a[7:0] == cfg_reg_offset) && (a[31:8] == 24'h000000);
  endfunction

  // a transfer is taken only when selected, bus ready and htrans is NONSEQ (SEQ is not taken)
  function automatic logic bus_take(input logic       sel,
                                    input logic       rdy,
                                    input logic [1:0] trans);
    bus_take = sel && rdy && (trans == htrans_nonseq);
  endfunction

  // address phase capture; slave always answers in zero wait states
  assign addr_hit = bus_take(hsel, hready, htrans) && is_cfg_addr(haddr);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_pending <= 1'b0;
    end else begin
      wr_pending <= addr_hit && hwrite;
    end
  end

  // single register: no wait states and no error responses, ever
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // configuration bits survive sleep because sleep never touches them
  // the fsm reset bit is not stored here; it reads back from the counter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg <= '{speed_led_select: cfg_reset_value[bit_speed_led],
               duplex_led_function: cfg_reset_value[bit_duplex_led],
               auto_power_save_en: cfg_reset_value[bit_auto_pwr],
               preamble_skip_en: cfg_reset_value[bit_preamble],
               sleep: cfg_reset_value[bit_sleep],
               remote_loopback_en: cfg_reset_value[bit_loopback]};
    end else if (wr_pending) begin
      cfg.speed_led_select    <= hwdata[bit_speed_led];
      cfg.duplex_led_function <= hwdata[bit_duplex_led];
      cfg.auto_power_save_en  <= hwdata[bit_auto_pwr];
      cfg.preamble_skip_en    <= hwdata[bit_preamble];
      cfg.sleep               <= hwdata[bit_sleep];
      cfg.remote_loopback_en  <= hwdata[bit_loopback];
    end
  end

  // state machine reset pulse: software write or wake from sleep
  // a new request while the count runs starts it again from the top
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sleep_prev  <= 1'b0;
      reset_count <= 3'h0;
    end else begin
      sleep_prev <= cfg.sleep;
      if (wr_pending && hwdata[bit_fsm_reset]) begin
        reset_count <= 3'(fsm_reset_cycles);
      end else if (sleep_prev && !cfg.sleep) begin
        reset_count <= 3'(fsm_reset_cycles);
      end else if (reset_count != 3'h0) begin
        reset_count <= reset_count - 3'h1;
      end
    end
  end

  // line status comes from other domains, two stages before use
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= line_status;
      sync2 <= sync1;
    end
  end

  // idle flag synchronised on its own; only the second stage is read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idle_s1 <= 1'b0;
      idle_s2 <= 1'b0;
    end else begin
      idle_s1 <= line_idle;
      idle_s2 <= idle_s1;
    end
  end

  // speed pin: link speed normally, detector level only in debug mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      speed_indicator_pin <= 1'b0;
    end else if (cfg.speed_led_select) begin
      speed_indicator_pin <= sync2.rx_signal_present;
    end else begin
      speed_indicator_pin <= sync2.link_up && sync2.speed_100;
    end
  end

  // duplex pin: collision is folded in only when software asks for it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      duplex_collision_pin <= 1'b0;
    end else if (cfg.duplex_led_function) begin
      duplex_collision_pin <= sync2.full_duplex || sync2.collision;
    end else begin
      duplex_collision_pin <= sync2.full_duplex;
    end
  end

  // power down needs both the enable and a quiet line
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reduced_power_down <= 1'b0;
    end else begin
      reduced_power_down <= cfg.auto_power_save_en && idle_s2;
    end
  end

  // state machines are held in reset while the counter runs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fsm_reset_active <= 1'b0;
    end else begin
      fsm_reset_active <= (reset_count != 3'h0);
    end
  end

  // loopback is held off while asleep; the stored bit itself is kept
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      preamble_skip_en   <= cfg_reset_value[bit_preamble];
      sleep_power_down   <= cfg_reset_value[bit_sleep];
      remote_loopback_en <= cfg_reset_value[bit_loopback];
    end else begin
      preamble_skip_en   <= cfg.preamble_skip_en;
      sleep_power_down   <= cfg.sleep;
      remote_loopback_en <= cfg.remote_loopback_en && !cfg.sleep;
    end
  end

  // read data; fsm reset bit reads 1 until its reset has completed
  always_comb begin
    read_value                = 16'h0000;
    read_value[bit_speed_led] = cfg.speed_led_select;
    read_value[bit_duplex_led] = cfg.duplex_led_function;
    read_value[bit_auto_pwr]  = cfg.auto_power_save_en;
    read_value[bit_fsm_reset] = (reset_count != 3'h0);
    read_value[bit_preamble]  = cfg.preamble_skip_en;
    read_value[bit_sleep]     = cfg.sleep;
    read_value[bit_loopback]  = cfg.remote_loopback_en;
  end

  // read data registered at the address phase edge; unmapped reads zero
  // hsize is ignored: the register is always handed over as a whole word
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_hit && !hwrite) begin
      hrdata <= {16'h0000, read_value & cfg_rw_mask};
    end else if (bus_take(hsel, hready, htrans)) begin
      hrdata <= 32'h00000000;
    end
  end
endmodule

// ==== phy_cfg_pkg.sv ====
// constants and types for the transceiver configuration register bank
// assumes a 32-bit AHB-Lite register bus and a 20 MHz clock
package phy_cfg_pkg;
  localparam logic [7:0]  cfg_reg_offset   = 8'h10;
  localparam int          bit_speed_led    = 6;
  localparam int          bit_duplex_led   = 5;
  localparam int          bit_auto_pwr     = 4;
  localparam int          bit_fsm_reset    = 3;
  localparam int          bit_preamble     = 2;
  localparam int          bit_sleep        = 1;
  localparam int          bit_loopback     = 0;
  localparam logic [15:0] cfg_reset_value  = 16'h0014;
  localparam logic [15:0] cfg_rw_mask      = 16'h007F;
  localparam int          fsm_reset_ns     = 200;
  localparam int          clk_period_ns    = 50;
  localparam int          fsm_reset_cycles = (fsm_reset_ns + clk_period_ns - 1) / clk_period_ns;
  localparam logic [1:0]  htrans_nonseq    = 2'h2;

  typedef struct packed {
    logic speed_led_select;
    logic duplex_led_function;
    logic auto_power_save_en;
    logic preamble_skip_en;
    logic sleep;
    logic remote_loopback_en;
  } cfg_t;

  typedef struct packed {
    logic link_up;
    logic speed_100;
    logic full_duplex;
    logic collision;
    logic rx_signal_present;
  } line_status_t;
endpackage

// ==== phy_line_model.sv ====
// line side model: status levels and idle flag seen by the block
// assumes the bench sets the wanted pattern between clock edges
`timescale 1ns/100ps
module phy_line_model
  import phy_cfg_pkg::*;
(
  input  wire logic   clk,
  input  wire logic [4:0] pattern,
  input  wire logic   idle_req,
  output phy_cfg_pkg::line_status_t line_status,
  output logic        line_idle
);
  // registered so levels move only after an edge, as real line logic would
  always_ff @(posedge clk) begin
    line_status <= pattern;
    line_idle   <= idle_req;
  end
endmodule

// ==== phy_cfg_monitor.sv ====
// port checker for the configuration bits block
// assumes a bind from the bench top, one clock domain
`timescale 1ns/100ps
module phy_cfg_monitor
  import phy_cfg_pkg::*;
(
  input wire logic         clk,
  input wire logic         resetn,
  input wire logic         hreadyout,
  input wire line_status_t line_status,
  input wire logic         line_idle,
  input wire logic         speed_indicator_pin,
  input wire logic         duplex_collision_pin,
  input wire logic         reduced_power_down,
  input wire logic         fsm_reset_active,
  input wire logic         preamble_skip_en,
  input wire logic         sleep_power_down,
  input wire logic         remote_loopback_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // six quiet cycles cover the two-stage sync plus the output register
  chk_zero_wait: assert property (hreadyout) else $error("bus wait state seen");
  chk_preamble_init: assert property ($rose(resetn) |-> preamble_skip_en)
    else $error("preamble skip not set after reset");
  chk_speed_quiet: assert property ((!line_status.link_up && !line_status.rx_signal_present)[*6]
    |-> !speed_indicator_pin) else $error("speed pin lit with no source");
  chk_duplex_quiet: assert property ((!line_status.full_duplex && !line_status.collision)[*6]
    |-> !duplex_collision_pin) else $error("duplex pin lit with no source");
  chk_power_idle: assert property ((!line_idle)[*6] |-> !reduced_power_down)
    else $error("power down while line busy");
  chk_reset_len: assert property ($rose(fsm_reset_active) |-> fsm_reset_active[*4] ##1 !fsm_reset_active)
    else $error("state machine reset length wrong");
  chk_wake_reset: assert property ($fell(sleep_power_down) |-> ##[0:2] fsm_reset_active)
    else $error("no reset on wake");
  chk_loop_sleep: assert property (sleep_power_down |-> !remote_loopback_en)
    else $error("loopback active in sleep");
  cover property ($rose(fsm_reset_active));
  cover property ($fell(sleep_power_down));
  cover property (reduced_power_down);
endmodule

// ==== phy_specific_config_bits_bench.sv ====
// self-checking bench for the configuration bits block
// assumes one AHB-Lite master here and the line model beside the block
`timescale 1ns/100ps
module phy_specific_config_bits_bench;
  import phy_cfg_pkg::*;
  logic         clk      = 1'b0;
  logic         resetn   = 1'b0;
  logic         hsel     = 1'b0;
  logic         hwrite   = 1'b0;
  logic         idle_req = 1'b0;
  logic [31:0]  haddr    = 32'h00000000;
  logic [31:0]  hwdata   = 32'h00000000;
  logic [31:0]  hrdata;
  logic [31:0]  r;
  logic [1:0]   htrans   = 2'h0;
  logic [4:0]   pattern  = 5'h00;
  logic         hreadyout, hresp, spd, dpx, rpd, fra, pse, slp, rle, line_idle;
  line_status_t line_status;
  int           errors = 0, checked = 0;
  always #25 clk = ~clk;
  phy_line_model i_phy_line_model(.clk(clk), .pattern(pattern), .idle_req(idle_req),
    .line_status(line_status), .line_idle(line_idle));
  phy_specific_config_bits i_phy_specific_config_bits(.clk(clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .line_status(line_status), .line_idle(line_idle), .speed_indicator_pin(spd),
    .duplex_collision_pin(dpx), .reduced_power_down(rpd), .fsm_reset_active(fra),
    .preamble_skip_en(pse), .sleep_power_down(slp), .remote_loopback_en(rle));
  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // one single word transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= htrans_nonseq;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", 32'h0, hresp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_reset;
    xfer(1'b0, 32'h10, 32'h0);
    chk("cfg reset", 32'h14, r);
    chk("preamble pin", 32'h1, pse);
    xfer(1'b1, 32'h14, 32'h7F);
    xfer(1'b0, 32'h14, 32'h0);
    chk("unmapped", 32'h0, r);
    xfer(1'b0, 32'h10, 32'h0);
    chk("cfg kept", 32'h14, r);
  endtask
  // link up slow, half duplex, collision and signal present
  task automatic t_leds;
    pattern <= 5'h13;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 32'h10, 32'(i << 5) | 32'h10);
      tick(6);
      chk("speed pin", 32'(i[1]), spd);
      chk("duplex pin", 32'(i[0]), dpx);
      chk("preamble off", 32'h0, pse);
    end
  endtask
  // fast full duplex link, no collision, no signal present flag
  task automatic t_power;
    @(posedge clk);
    idle_req <= 1'b1;
    pattern  <= 5'h1C;
    tick(6);
    chk("power down on", 32'h1, rpd);
    chk("speed debug", 32'h0, spd);
    xfer(1'b1, 32'h10, 32'h0);
    tick(3);
    chk("power down off", 32'h0, rpd);
    chk("speed normal", 32'h1, spd);
    chk("duplex only", 32'h1, dpx);
    @(posedge clk);
    idle_req <= 1'b0;
  endtask
  task automatic t_fsm;
    xfer(1'b1, 32'h10, 32'h8);
    tick(2);
    chk("fsm reset busy", 32'h1, fra);
    xfer(1'b0, 32'h10, 32'h0);
    chk("fsm bit busy", 32'h8, r);
    tick(8);
    chk("fsm reset done", 32'h0, fra);
    xfer(1'b0, 32'h10, 32'h0);
    chk("fsm bit", 32'h0, r);
  endtask
  task automatic t_sleep;
    xfer(1'b1, 32'h10, 32'h33);
    tick(2);
    chk("asleep", 32'h1, slp);
    chk("loop gated", 32'h0, rle);
    xfer(1'b0, 32'h10, 32'h0);
    chk("cfg in sleep", 32'h33, r);
    xfer(1'b1, 32'h10, 32'h31);
    tick(2);
    chk("wake reset", 32'h1, fra);
    tick(6);
    xfer(1'b0, 32'h10, 32'h0);
    chk("cfg after wake", 32'h31, r);
    chk("loopback", 32'h1, rle);
  endtask
  // reset in mid-run brings every bit back to its reset value
  task automatic t_rereset;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    tick(2);
    chk("preamble reset", 32'h1, pse);
    chk("loopback reset", 32'h0, rle);
    xfer(1'b0, 32'h10, 32'h0);
    chk("cfg re-reset", 32'h14, r);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset;
    t_leds;
    t_power;
    t_fsm;
    t_sleep;
    t_rereset;
    end_sim;
  end
  // the tests need about 120 cycles; this only cuts a hang
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    end_sim;
  end
endmodule
bind phy_specific_config_bits phy_cfg_monitor i_phy_cfg_monitor(.clk, .resetn, .hreadyout,
  .line_status, .line_idle, .speed_indicator_pin, .duplex_collision_pin, .reduced_power_down,
  .fsm_reset_active, .preamble_skip_en, .sleep_power_down, .remote_loopback_en);
